// ===== tsx_pkg.sv
// Overview of operation
// - sixteen-bit literal register loads the ADC channel select on its control option
// - software writes to the literal are ignored while enabled and started
// - control option 0010 disables the step delay timer, 0110 enables it
// - options 1000/1001 start timer 0/1 and stall until it reaches its limit
// - option 1011 waits for a low-to-high edge of the software trigger bit
// - options 1100, 1101, 1110 copy counter 0, counter 1, literal to channel select
// - option 1111 pulses every trigger output enabled in the broadcast register
// - add options 0000..0101 add the adjust value to one of six targets
// - copy options 1000..1101 load the hold value into one of six targets
// - reserved commands and options act as no-operation steps then advance
package tsx_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] TSX_OFS_CTRL     = 8'h00;
   localparam logic [7:0] TSX_OFS_LITERAL  = 8'h04;
   localparam logic [7:0] TSX_OFS_ADJUST   = 8'h08;
   localparam logic [7:0] TSX_OFS_HOLD     = 8'h0C;
   localparam logic [7:0] TSX_OFS_BTE      = 8'h10;
   localparam logic [7:0] TSX_OFS_C0LIM    = 8'h14;
   localparam logic [7:0] TSX_OFS_C1LIM    = 8'h18;
   localparam logic [7:0] TSX_OFS_T0LIM    = 8'h1C;
   localparam logic [7:0] TSX_OFS_T1LIM    = 8'h20;
   localparam logic [7:0] TSX_OFS_SDLIM    = 8'h24;
   localparam logic [7:0] TSX_OFS_CHSEL    = 8'h28;
   localparam logic [7:0] TSX_OFS_STATUS   = 8'h2C;
   localparam logic [7:0] TSX_OFS_CMD      = 8'h30;
   // ctrl register bits
   localparam int TSX_BIT_ENABLE = 0;
   localparam int TSX_BIT_START  = 1;
   localparam int TSX_BIT_SWT    = 2;
   localparam int TSX_BIT_SDEN   = 3;
   localparam logic [15:0] TSX_RST_LITERAL = 16'h0000;
   localparam logic [15:0] TSX_RST_WORD    = 16'h0000;
   // command opcodes (upper nibble of the step byte)
   localparam logic [3:0] TSX_OP_CTRL = 4'h0;
   localparam logic [3:0] TSX_OP_ADD  = 4'h1;
   localparam logic [3:0] TSX_OP_COPY = 4'h2;
   // control options
   localparam logic [3:0] TSX_CO_SD_OFF  = 4'h2;
   localparam logic [3:0] TSX_CO_SD_ON   = 4'h6;
   localparam logic [3:0] TSX_CO_T0      = 4'h8;
   localparam logic [3:0] TSX_CO_T1      = 4'h9;
   localparam logic [3:0] TSX_CO_SWT     = 4'hB;
   localparam logic [3:0] TSX_CO_C0CH    = 4'hC;
   localparam logic [3:0] TSX_CO_C1CH    = 4'hD;
   localparam logic [3:0] TSX_CO_LITCH   = 4'hE;
   localparam logic [3:0] TSX_CO_BCAST   = 4'hF;
   // add/copy target range
   localparam logic [3:0] TSX_ADD_LAST   = 4'h5;
   localparam logic [3:0] TSX_COPY_FIRST = 4'h8;
   localparam logic [3:0] TSX_COPY_LAST  = 4'hD;
   localparam int TSX_NUM_TARGETS = 6;
   localparam int TSX_TGT_LITERAL = 5;
   typedef enum logic [1:0] {TSX_IDLE, TSX_WAIT_TMR, TSX_WAIT_SWT} tsx_state_e;
endpackage : tsx_pkg

// ===== tsx_step_timer.sv
`timescale 1ns/1ps
// one-shot counter started by a pulse, stops at its limit and reports a one-cycle match there
module tsx_step_timer
   import tsx_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             start,
   input  wire logic [WIDTH-1:0] limit,
   output logic                  match
);
   initial begin
      if (WIDTH < 1) $error("timer width must be positive");
   end
   logic [WIDTH-1:0] count_q;
   logic             run_q;
   always_ff @(posedge mclk) begin
      if (rst || start) begin
         count_q <= '0;
      end else if (run_q) begin
         count_q <= count_q + 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         run_q <= 1'b0;
      end else if (start) begin
         run_q <= 1'b1;
      end else if (run_q && count_q == limit) begin
         run_q <= 1'b0;
      end
   end
   assign match = run_q && (count_q == limit);
endmodule : tsx_step_timer

// ===== tsx_apb_regs.sv
`timescale 1ns/1ps
// apb decode: single-cycle access phase, unmapped addresses read zero and raise pslverr
module tsx_apb_regs
   import tsx_pkg::*;
(
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   output logic             pready,
   output logic             pslverr,
   output logic             wr_en,
   output logic [7:0]       wr_ofs,
   output logic             mapped
);
   assign pready  = 1'b1;
   assign wr_en   = psel && penable && pwrite;
   assign wr_ofs  = paddr;
   always_comb begin
      mapped = (paddr[1:0] == 2'b00) && (paddr <= TSX_OFS_CMD);
   end
   assign pslverr = psel && penable && !mapped;
endmodule : tsx_apb_regs

// ===== tsx_step_exec.sv
`timescale 1ns/1ps
module tsx_step_exec
   import tsx_pkg::*;
#(
   parameter int NUM_TRIG = 16
) (
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [15:0]         counter0_value,
   input  wire logic [15:0]         counter1_value,
   output logic [15:0]              adc_channel_select,
   output logic [NUM_TRIG-1:0]      trigger_out,
   output logic                     step_delay_enable
);
   initial begin
      if (NUM_TRIG < 1 || NUM_TRIG > 16) $error("NUM_TRIG must be 1..16");
   end

   // ==========================================================
   // bus decode
   logic       wr_en;
   logic [7:0] wr_ofs;
   logic       mapped;
   tsx_apb_regs u_apb (
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pready  (pready),
      .pslverr (pslverr),
      .wr_en   (wr_en),
      .wr_ofs  (wr_ofs),
      .mapped  (mapped)
   );

   // ==========================================================
   // registers
   logic                enable_q;
   logic                start_q;
   logic                swt_q;
   logic                swt_prev_q;
   logic                sden_q;
   logic [15:0]         literal_q;
   logic [15:0]         adjust_q;
   logic [15:0]         hold_q;
   logic [NUM_TRIG-1:0] bte_q;
   logic [15:0]         tgt_q [TSX_NUM_TARGETS];
   logic [15:0]         chsel_q;
   logic [NUM_TRIG-1:0] trig_q;
   logic [7:0]          cmd_q;
   logic                cmd_pend_q;
   tsx_state_e          state_q;
   logic                running;
   logic                wait_t1_q;
   logic                t0_start;
   logic                t1_start;
   logic                t0_match;
   logic                t1_match;
   logic [3:0]          op;
   logic [3:0]          opt;
   logic                exec;
   logic                add_hit;
   logic                copy_hit;
   logic [2:0]          add_idx;
   logic [2:0]          copy_idx;
   logic                ctl_step;
   logic                sd_off_step;
   logic                sd_on_step;
   logic                swt_step;
   logic                chsel_step;
   logic                bcast_step;

   assign running = enable_q && start_q;
   assign op      = cmd_q[7:4];
   assign opt     = cmd_q[3:0];
   assign exec    = cmd_pend_q && running && state_q == TSX_IDLE;
   assign add_hit  = exec && op == TSX_OP_ADD && opt <= TSX_ADD_LAST;
   assign copy_hit = exec && op == TSX_OP_COPY && opt >= TSX_COPY_FIRST
                     && opt <= TSX_COPY_LAST;
   assign add_idx  = opt[2:0];
   assign copy_idx = 3'(opt - TSX_COPY_FIRST);
   assign ctl_step    = exec && op == TSX_OP_CTRL;
   assign sd_off_step = ctl_step && opt == TSX_CO_SD_OFF;
   assign sd_on_step  = ctl_step && opt == TSX_CO_SD_ON;
   assign swt_step    = ctl_step && opt == TSX_CO_SWT;
   assign chsel_step  = ctl_step && (opt == TSX_CO_C0CH || opt == TSX_CO_C1CH
                                     || opt == TSX_CO_LITCH);
   assign bcast_step  = ctl_step && opt == TSX_CO_BCAST;

   always_ff @(posedge mclk) begin
      if (rst) begin
         enable_q <= 1'b0;
         start_q  <= 1'b0;
         swt_q    <= 1'b0;
      end else if (wr_en && wr_ofs == TSX_OFS_CTRL) begin
         enable_q <= pwdata[TSX_BIT_ENABLE];
         start_q  <= pwdata[TSX_BIT_START];
         swt_q    <= pwdata[TSX_BIT_SWT];
      end
   end

   // a step beats a software write landing in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         sden_q <= 1'b0;
      end else if (sd_off_step) begin
         sden_q <= 1'b0;
      end else if (sd_on_step) begin
         sden_q <= 1'b1;
      end else if (wr_en && wr_ofs == TSX_OFS_CTRL) begin
         sden_q <= pwdata[TSX_BIT_SDEN];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         adjust_q <= TSX_RST_WORD;
      end else if (wr_en && wr_ofs == TSX_OFS_ADJUST) begin
         adjust_q <= pwdata[15:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         hold_q <= TSX_RST_WORD;
      end else if (wr_en && wr_ofs == TSX_OFS_HOLD) begin
         hold_q <= pwdata[15:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         bte_q <= '0;
      end else if (wr_en && wr_ofs == TSX_OFS_BTE) begin
         bte_q <= pwdata[NUM_TRIG-1:0];
      end
   end

   // ==========================================================
   // limit targets and literal; step writes win over software
   genvar gi;
   generate
      for (gi = 0; gi < TSX_NUM_TARGETS; gi++) begin : g_tgt
         localparam logic [7:0] OFS = (gi == TSX_TGT_LITERAL) ? TSX_OFS_LITERAL
                                      : 8'(TSX_OFS_C0LIM + 8'(4 * gi));
         logic sw_ok;
         assign sw_ok = (gi != TSX_TGT_LITERAL) || !running;
         always_ff @(posedge mclk) begin
            if (rst) begin
               tgt_q[gi] <= TSX_RST_LITERAL;
            end else if (add_hit && add_idx == 3'(gi)) begin
               tgt_q[gi] <= 16'(tgt_q[gi] + adjust_q);
            end else if (copy_hit && copy_idx == 3'(gi)) begin
               tgt_q[gi] <= hold_q;
            end else if (wr_en && wr_ofs == OFS && sw_ok) begin
               tgt_q[gi] <= pwdata[15:0];
            end
         end
      end
   endgenerate
   assign literal_q = tgt_q[TSX_TGT_LITERAL];

   // ==========================================================
   // command slot: software posts one step byte, pending flag cleared when executed, byte kept
   always_ff @(posedge mclk) begin
      if (rst) begin
         cmd_q      <= 8'h00;
         cmd_pend_q <= 1'b0;
      end else if (exec) begin
         cmd_pend_q <= 1'b0;
      end else if (wr_en && wr_ofs == TSX_OFS_CMD && !cmd_pend_q) begin
         cmd_q      <= pwdata[7:0];
         cmd_pend_q <= 1'b1;
      end
   end

   // ==========================================================
   // wait states
   assign t0_start = exec && op == TSX_OP_CTRL && opt == TSX_CO_T0;
   assign t1_start = exec && op == TSX_OP_CTRL && opt == TSX_CO_T1;

   // each timer restarts from zero on its start pulse
   tsx_step_timer #(.WIDTH(16)) u_t0 (
      .mclk  (mclk),
      .rst   (rst),
      .start (t0_start),
      .limit (tgt_q[2]),
      .match (t0_match)
   );
   tsx_step_timer #(.WIDTH(16)) u_t1 (
      .mclk  (mclk),
      .rst   (rst),
      .start (t1_start),
      .limit (tgt_q[3]),
      .match (t1_match)
   );

   // previous value of the trigger bit, reset to its idle level
   always_ff @(posedge mclk) begin
      if (rst) begin
         swt_prev_q <= 1'b0;
      end else begin
         swt_prev_q <= swt_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= TSX_IDLE;
      end else if (!running) begin
         state_q <= TSX_IDLE;
      end else begin
         case (state_q)
            TSX_IDLE: begin
               if (t0_start || t1_start) begin
                  state_q <= TSX_WAIT_TMR;
               end else if (swt_step) begin
                  state_q <= TSX_WAIT_SWT;
               end
            end
            TSX_WAIT_TMR: begin
               if (wait_t1_q ? t1_match : t0_match) state_q <= TSX_IDLE;
            end
            TSX_WAIT_SWT: begin
               if (swt_q && !swt_prev_q) state_q <= TSX_IDLE;
            end
            default: state_q <= TSX_IDLE;
         endcase
      end
   end

   // remembers which timer the current wait belongs to
   always_ff @(posedge mclk) begin
      if (rst) begin
         wait_t1_q <= 1'b0;
      end else if (t0_start || t1_start) begin
         wait_t1_q <= t1_start;
      end
   end

   // ==========================================================
   // outputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         chsel_q <= TSX_RST_WORD;
      end else if (chsel_step) begin
         case (opt)
            TSX_CO_C0CH:  chsel_q <= counter0_value;
            TSX_CO_C1CH:  chsel_q <= counter1_value;
            TSX_CO_LITCH: chsel_q <= literal_q;
            default:      chsel_q <= chsel_q;
         endcase
      end else if (wr_en && wr_ofs == TSX_OFS_CHSEL) begin
         chsel_q <= pwdata[15:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         trig_q <= '0;
      end else if (bcast_step) begin
         trig_q <= bte_q;
      end else begin
         trig_q <= '0;
      end
   end

   assign adc_channel_select = chsel_q;
   assign trigger_out        = trig_q;
   assign step_delay_enable  = sden_q;

   // ==========================================================
   // read mux
   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && mapped) begin
         case (paddr)
            TSX_OFS_CTRL:    prdata = {28'h000_0000, sden_q, swt_q, start_q, enable_q};
            TSX_OFS_LITERAL: prdata = {16'h0000, tgt_q[5]};
            TSX_OFS_ADJUST:  prdata = {16'h0000, adjust_q};
            TSX_OFS_HOLD:    prdata = {16'h0000, hold_q};
            TSX_OFS_BTE:     prdata = 32'(bte_q);
            TSX_OFS_C0LIM:   prdata = {16'h0000, tgt_q[0]};
            TSX_OFS_C1LIM:   prdata = {16'h0000, tgt_q[1]};
            TSX_OFS_T0LIM:   prdata = {16'h0000, tgt_q[2]};
            TSX_OFS_T1LIM:   prdata = {16'h0000, tgt_q[3]};
            TSX_OFS_SDLIM:   prdata = {16'h0000, tgt_q[4]};
            TSX_OFS_CHSEL:   prdata = {16'h0000, chsel_q};
            TSX_OFS_STATUS:  prdata = {29'h0000_0000, cmd_pend_q, 2'(state_q)};
            TSX_OFS_CMD:     prdata = {24'h00_0000, cmd_q};
            default:         prdata = 32'h0000_0000;
         endcase
      end
   end
endmodule : tsx_step_exec

// ===== tsx_step_exec_monitor.sv
`timescale 1ns/1ps
module tsx_step_exec_monitor
   import tsx_pkg::*;
#(
   parameter int NUM_TRIG = 16
) (
   input wire logic                mclk,
   input wire logic                rst,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [7:0]          paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire logic [15:0]         counter0_value,
   input wire logic [15:0]         counter1_value,
   input wire logic [15:0]         adc_channel_select,
   input wire logic [NUM_TRIG-1:0] trigger_out,
   input wire logic                step_delay_enable
);
   // ==========
   // bus decode
   logic                wr, cmd_ok, ctl, bcast_cmd, chsel_cmd, chsel_wr, nop_cmd;
   logic                en_q, st_q, wait_q;
   logic [NUM_TRIG-1:0] bte_q;
   assign wr        = psel & penable & pwrite;
   assign cmd_ok    = wr & (paddr == TSX_OFS_CMD) & en_q & st_q & ~wait_q;
   assign ctl       = cmd_ok & (pwdata[7:4] == TSX_OP_CTRL);
   assign bcast_cmd = ctl & (pwdata[3:0] == TSX_CO_BCAST);
   assign chsel_cmd = ctl & (pwdata[3:0] inside {TSX_CO_C0CH, TSX_CO_C1CH, TSX_CO_LITCH});
   assign chsel_wr  = wr & (paddr == TSX_OFS_CHSEL);
   assign nop_cmd   = cmd_ok & ((pwdata[7:4] > TSX_OP_COPY)
                      | (ctl & (pwdata[3:0] inside {4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h7, 4'hA})));
   always_ff @(posedge mclk) begin
      if (rst) begin
         en_q <= 1'b0;
         st_q <= 1'b0;
      end else if (wr && paddr == TSX_OFS_CTRL) begin
         en_q <= pwdata[TSX_BIT_ENABLE];
         st_q <= pwdata[TSX_BIT_START];
      end
   end
   // a wait is taken as over at the next ctrl write
   always_ff @(posedge mclk) begin
      if (rst || (wr && paddr == TSX_OFS_CTRL)) begin
         wait_q <= 1'b0;
      end else if (ctl && (pwdata[3:0] inside {TSX_CO_T0, TSX_CO_T1, TSX_CO_SWT})) begin
         wait_q <= 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         bte_q <= '0;
      end else if (wr && paddr == TSX_OFS_BTE) begin
         bte_q <= pwdata[NUM_TRIG-1:0];
      end
   end
   // ==========
   // properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   c0_copy_a : assert property (ctl && pwdata[3:0] == TSX_CO_C0CH
      |-> ##2 adc_channel_select == $past(counter0_value)) else $error("chsel not counter 0");
   c1_copy_a : assert property (ctl && pwdata[3:0] == TSX_CO_C1CH
      |-> ##2 adc_channel_select == $past(counter1_value)) else $error("chsel not counter 1");
   bcast_pulse_a : assert property (bcast_cmd
      |-> ##2 trigger_out == bte_q ##1 trigger_out == '0) else $error("broadcast pulse wrong");
   trig_cause_a : assert property (trigger_out != '0
      |-> $past(bcast_cmd, 2)) else $error("trigger without broadcast step");
   sd_off_a : assert property (ctl && pwdata[3:0] == TSX_CO_SD_OFF
      |-> ##2 !step_delay_enable) else $error("step delay still enabled");
   sd_on_a : assert property (ctl && pwdata[3:0] == TSX_CO_SD_ON
      |-> ##2 step_delay_enable) else $error("step delay not enabled");
   nop_quiet_a : assert property (nop_cmd |-> ##2 $stable(adc_channel_select)
      && $stable(step_delay_enable) && trigger_out == '0) else $error("reserved step acted");
   chsel_cause_a : assert property (!$past(rst) && $changed(adc_channel_select)
      |-> $past(chsel_cmd, 2) || $past(chsel_wr)) else $error("chsel changed without cause");
   apb_ready_a : assert property (psel && penable |-> pready) else $error("pready low");
   unmapped_err_a : assert property (psel && penable && (paddr[1:0] != 2'b00
      || paddr > TSX_OFS_CMD) |-> pslverr && prdata == '0) else $error("unmapped not refused");
   cover property (bcast_cmd);
   cover property (chsel_cmd);
   cover property ($rose(wait_q));
   cover property (nop_cmd);
endmodule : tsx_step_exec_monitor

bind tsx_step_exec tsx_step_exec_monitor #(.NUM_TRIG(NUM_TRIG)) i_tsx_step_exec_monitor (
   .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .counter0_value(counter0_value), .counter1_value(counter1_value),
   .adc_channel_select(adc_channel_select), .trigger_out(trigger_out),
   .step_delay_enable(step_delay_enable));

// ===== tsx_far_model.sv
`timescale 1ns/1ps
// trigger consumers: two counters that step on trigger lines 0 and 1
module tsx_far_model
#(
   parameter logic [15:0] C0_INIT = 16'h0100,
   parameter logic [15:0] C1_INIT = 16'h0200
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [15:0] trigger_out,
   output logic [15:0]      counter0_value,
   output logic [15:0]      counter1_value
);
   always_ff @(posedge mclk) begin
      if (rst) begin
         counter0_value <= C0_INIT;
         counter1_value <= C1_INIT;
      end else begin
         counter0_value <= counter0_value + 16'(trigger_out[0]);
         counter1_value <= counter1_value + 16'(trigger_out[1]);
      end
   end
endmodule : tsx_far_model

// ===== tb_tsx_step_exec.sv
`timescale 1ns/1ps
module tb_tsx_step_exec
   import tsx_pkg::*;
   ;
   localparam logic [15:0] C0 = 16'h0100;
   localparam logic [15:0] C1 = 16'h0200;
   typedef struct packed {logic [7:0] cmd; logic [15:0] ch; logic [15:0] tr; logic sd;} tsx_row_s;
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr, sden, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] c0, c1, chsel, trig;
   int          cyc, t0, n_fail, tests_run;
   logic [7:0]  bad [2] = '{8'h34, 8'h05};
   tsx_row_s    rows [12] = '{'{8'h0E, 16'hA5C3, 16'h0, 1'b0}, '{8'h06, 16'hA5C3, 16'h0, 1'b1},
      '{8'h02, 16'hA5C3, 16'h0, 1'b0}, '{8'h0F, 16'hA5C3, 16'h0003, 1'b0},
      '{8'h0C, C0 + 16'h1, 16'h0, 1'b0}, '{8'h0D, C1 + 16'h1, 16'h0, 1'b0},
      '{8'h15, C1 + 16'h1, 16'h0, 1'b0}, '{8'h0E, 16'hA5D4, 16'h0, 1'b0},
      '{8'h2D, 16'hA5D4, 16'h0, 1'b0}, '{8'h0E, 16'h0200, 16'h0, 1'b0},
      '{8'h00, 16'h0200, 16'h0, 1'b0}, '{8'h3E, 16'h0200, 16'h0, 1'b0}};
   tsx_step_exec i_tsx_step_exec (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .counter0_value(c0), .counter1_value(c1),
      .adc_channel_select(chsel), .trigger_out(trig), .step_delay_enable(sden));
   tsx_far_model #(.C0_INIT(C0), .C1_INIT(C1)) i_tsx_far_model (.mclk(mclk), .rst(rst),
      .trigger_out(trig), .counter0_value(c0), .counter1_value(c1));
   // ==========
   // helpers
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      forever begin
         @(posedge mclk);
         cyc++;
         if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
         end
      end
   end
   // ==========
   // main sequence
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, TSX_OFS_LITERAL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, TSX_OFS_LITERAL, 32'hA5C3);
      apb(1'b1, TSX_OFS_ADJUST, 32'h0011);
      apb(1'b1, TSX_OFS_HOLD, 32'h0200);
      apb(1'b1, TSX_OFS_BTE, 32'h0003);
      apb(1'b1, TSX_OFS_CTRL, 32'h3);
      foreach (rows[i]) begin
         apb(1'b1, TSX_OFS_CMD, 32'(rows[i].cmd));
         @(posedge mclk);
         #1;
         chk(32'(chsel), 32'(rows[i].ch));
         chk(32'(trig), 32'(rows[i].tr));
         chk(32'(sden), 32'(rows[i].sd));
      end
      apb(1'b1, TSX_OFS_LITERAL, 32'h7777);
      apb(1'b0, TSX_OFS_LITERAL, 32'h0);
      chk(rd, 32'h0200);
      apb(1'b1, TSX_OFS_ADJUST, 32'hFFF0);
      apb(1'b1, TSX_OFS_HOLD, 32'h0020);
      for (int k = 0; k < 5; k++) begin
         apb(1'b1, TSX_OFS_CMD, 32'(8'h28 + k));
         apb(1'b1, TSX_OFS_CMD, 32'(8'h10 + k));
         apb(1'b0, 8'(TSX_OFS_C0LIM + 4 * k), 32'h0);
         chk(rd, 32'h0010);
      end
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, TSX_OFS_CMD, 32'(8'h08 + k));
         t0 = cyc;
         apb(1'b0, TSX_OFS_STATUS, 32'h0);
         chk(rd & 32'h3, 32'h1);
         do apb(1'b0, TSX_OFS_STATUS, 32'h0); while (rd[1:0] !== 2'b00);
         chk(32'(cyc - t0 >= 16), 32'h1);
         chk(32'(cyc - t0 <= 24), 32'h1);
         apb(1'b1, TSX_OFS_CTRL, 32'h3);
      end
      apb(1'b1, TSX_OFS_CMD, 32'h0B);
      repeat (2) begin
         apb(1'b0, TSX_OFS_STATUS, 32'h0);
         chk(rd & 32'h3, 32'h2);
      end
      apb(1'b1, TSX_OFS_CTRL, 32'h7);
      apb(1'b0, TSX_OFS_STATUS, 32'h0);
      chk(rd & 32'h3, 32'h0);
      apb(1'b1, TSX_OFS_CTRL, 32'h3);
      foreach (bad[i]) begin
         apb(1'b0, bad[i], 32'h0);
         chk(rd, 32'h0);
         chk(32'(err), 32'h1);
      end
      // software write of the channel select
      apb(1'b1, TSX_OFS_CHSEL, 32'h1234);
      #1;
      chk(32'(chsel), 32'h1234);
      // a step posted while stopped waits; a second post while pending is refused
      apb(1'b1, TSX_OFS_CTRL, 32'h1);
      apb(1'b1, TSX_OFS_CMD, 32'h00);
      apb(1'b1, TSX_OFS_CMD, 32'h0E);
      apb(1'b0, TSX_OFS_CMD, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, TSX_OFS_STATUS, 32'h0);
      chk(rd, 32'h4);
      apb(1'b1, TSX_OFS_CTRL, 32'hB);
      apb(1'b0, TSX_OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
      chk({chsel, 15'h0, sden}, 32'h1234_0001);
      // reset in mid-run
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk({chsel, trig}, 32'h0);
      chk(32'(sden), 32'h0);
      apb(1'b0, TSX_OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, TSX_OFS_LITERAL, 32'h0);
      chk(rd, 32'h0);
      tally_and_finish();
   end
endmodule : tb_tsx_step_exec
